//--- shared/ncd_pkg.sv
/*
 Opcodes, instruction field layout and memory geometry for the 4-bit
 decoder core. Assumes one machine cycle per clock-enable pulse.
*/
// What this block does
// - Load copies memory to register; store reverses
// - Immediate written straight into memory, no skip
// - Port input/output by group and code
// - Chained subtract with borrow, skip variants
// - Register minus memory, plain and two skip variants
// - Skip on register equal or unequal memory
// - Register mask test, skip if all ones
// - Register mask test, skip if all zeros
// - Memory immediate mask, skip if all ones
// - Memory immediate mask, skip if all zeros
// - Skip when some masked memory bit zero
// - Skip when some masked memory bit one
// - Word: opcode, row, column, operand fields
// - General registers are memory 00h to 0fh
package ncd_pkg;
    // =========================================================
    // Instruction fields
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 10;
    localparam int ROW_MSB = 9;
    localparam int ROW_LSB = 8;
    localparam int COL_MSB = 7;
    localparam int COL_LSB = 4;
    localparam int OPD_MSB = 3;
    localparam int OPD_LSB = 0;
    localparam int MEM_WORDS = 64;
    localparam logic [1:0] GREG_ROW = 2'h0;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [3:0] NIB_ONES = 4'hf;

    // =========================================================
    // Opcodes
    localparam logic [5:0] OP_MEM_IMM_OR = 6'h06;
    localparam logic [5:0] OP_MEM_IMM_AND = 6'h07;
    localparam logic [5:0] OP_MEM_IMM_XOR = 6'h0e;
    localparam logic [5:0] OP_IMM_TO_MEM_WRITE = 6'h0f;
    localparam logic [5:0] OP_REG_MEM_OR = 6'h16;
    localparam logic [5:0] OP_REG_MEM_AND = 6'h17;
    localparam logic [5:0] OP_REG_MINUS_MEM = 6'h18;
    localparam logic [5:0] OP_REG_MINUS_MEM_SKIP_BORROW = 6'h19;
    localparam logic [5:0] OP_REG_MINUS_MEM_SKIP_NO_BORROW = 6'h1a;
    localparam logic [5:0] OP_CHAINED_DIFF = 6'h1b;
    localparam logic [5:0] OP_CHAINED_DIFF_SKIP_ON_BORROW = 6'h1c;
    localparam logic [5:0] OP_CHAINED_DIFF_SKIP_NO_BORROW = 6'h1d;
    localparam logic [5:0] OP_REG_MEM_XOR = 6'h1e;
    localparam logic [5:0] OP_SAME_ROW_COPY = 6'h1f;
    localparam logic [5:0] OP_REG_MASK_ALL_ONES_TEST = 6'h20;
    localparam logic [5:0] OP_REG_MASK_ALL_ZEROS_TEST = 6'h21;
    localparam logic [5:0] OP_CMP_REG_MEM_MATCH = 6'h22;
    localparam logic [5:0] OP_CMP_REG_MEM_MISMATCH = 6'h23;
    localparam logic [5:0] OP_MEM_TO_REG_COPY = 6'h24;
    localparam logic [5:0] OP_REG_TO_MEM_COPY = 6'h25;
    localparam logic [5:0] OP_INDIRECT_DEST_COPY = 6'h26;
    localparam logic [5:0] OP_INDIRECT_SRC_COPY = 6'h27;
    localparam logic [5:0] OP_CMP_IMM_BELOW = 6'h30;
    localparam logic [5:0] OP_CMP_IMM_AT_OR_ABOVE = 6'h31;
    localparam logic [5:0] OP_CMP_IMM_MATCH = 6'h32;
    localparam logic [5:0] OP_CMP_IMM_MISMATCH = 6'h33;
    localparam logic [5:0] OP_MEM_MASK_SOME_ZERO_TEST = 6'h34;
    localparam logic [5:0] OP_MEM_MASK_ALL_ONES_TEST = 6'h35;
    localparam logic [5:0] OP_MEM_MASK_SOME_ONE_TEST = 6'h36;
    localparam logic [5:0] OP_MEM_MASK_ALL_ZEROS_TEST = 6'h37;
    localparam logic [5:0] OP_PORT_READ_GROUP_ONE = 6'h38;
    localparam logic [5:0] OP_PORT_READ_GROUP_TWO = 6'h39;
    localparam logic [5:0] OP_PORT_READ_GROUP_THREE = 6'h3a;
    localparam logic [5:0] OP_PORT_WRITE_GROUP_ONE = 6'h3b;
    localparam logic [5:0] OP_PORT_WRITE_GROUP_TWO = 6'h3c;
    localparam logic [5:0] OP_PORT_WRITE_GROUP_THREE = 6'h3d;

    // Group numbers on the port matrix
    localparam logic [1:0] GRP_ONE = 2'h1;
    localparam logic [1:0] GRP_TWO = 2'h2;
    localparam logic [1:0] GRP_THREE = 2'h3;

    typedef enum {
        NCD_RUN,
        NCD_IN_WAIT
    } ncd_state_t;
endpackage

//--- src/ncd_alu.sv
/*
 Combinational operation unit: result, borrow and skip per opcode.
 Assumes operands already fetched from data memory by the caller.
*/
module ncd_alu
    import ncd_pkg::*;
(
    input wire logic [5:0] i_op,
    input wire logic [3:0] i_reg,
    input wire logic [3:0] i_mem,
    input wire logic [3:0] i_imm,
    input wire logic i_borrow,
    output logic [3:0] o_result,
    output logic o_borrow,
    output logic o_set_borrow,
    output logic o_skip,
    output logic o_wr_reg,
    output logic o_wr_mem
);
    logic [4:0] diff;
    logic chained;
    logic [3:0] rmask;
    logic [3:0] mmask;

    // =========================================================
    // Shared arithmetic
    always_comb begin
        chained = (i_op == OP_CHAINED_DIFF) ||
                  (i_op == OP_CHAINED_DIFF_SKIP_ON_BORROW) ||
                  (i_op == OP_CHAINED_DIFF_SKIP_NO_BORROW);
        diff = {1'b0, i_reg} - {1'b0, i_mem}
               - {4'h0, chained & i_borrow};
        rmask = i_reg & i_mem;
        mmask = i_mem & i_imm;
    end

    // =========================================================
    // Per-opcode behaviour
    always_comb begin
        o_result = NIB_ZERO;
        o_borrow = diff[4];
        o_set_borrow = 1'b0;
        o_skip = 1'b0;
        o_wr_reg = 1'b0;
        o_wr_mem = 1'b0;
        case (i_op)
            OP_REG_MINUS_MEM, OP_REG_MINUS_MEM_SKIP_BORROW,
            OP_REG_MINUS_MEM_SKIP_NO_BORROW, OP_CHAINED_DIFF,
            OP_CHAINED_DIFF_SKIP_ON_BORROW,
            OP_CHAINED_DIFF_SKIP_NO_BORROW: begin
                o_result = diff[3:0];
                o_wr_reg = 1'b1;
                o_set_borrow = 1'b1;
                if (i_op == OP_REG_MINUS_MEM_SKIP_BORROW ||
                    i_op == OP_CHAINED_DIFF_SKIP_ON_BORROW) begin
                    o_skip = diff[4];
                end else if (i_op == OP_REG_MINUS_MEM_SKIP_NO_BORROW ||
                             i_op == OP_CHAINED_DIFF_SKIP_NO_BORROW) begin
                    o_skip = ~diff[4];
                end
            end
            OP_CMP_REG_MEM_MATCH: o_skip = (i_reg == i_mem);
            OP_CMP_REG_MEM_MISMATCH: o_skip = (i_reg != i_mem);
            OP_REG_MASK_ALL_ONES_TEST: o_skip = (rmask == i_mem);
            OP_REG_MASK_ALL_ZEROS_TEST:
                o_skip = (rmask == NIB_ZERO);
            OP_MEM_MASK_ALL_ONES_TEST: o_skip = (mmask == i_imm);
            OP_MEM_MASK_ALL_ZEROS_TEST:
                o_skip = (mmask == NIB_ZERO);
            OP_MEM_MASK_SOME_ZERO_TEST:
                o_skip = (mmask != i_imm);
            OP_MEM_MASK_SOME_ONE_TEST:
                o_skip = (mmask != NIB_ZERO);
            OP_CMP_IMM_BELOW: o_skip = (i_mem < i_imm);
            OP_CMP_IMM_AT_OR_ABOVE: o_skip = (i_mem >= i_imm);
            OP_CMP_IMM_MATCH: o_skip = (i_mem == i_imm);
            OP_CMP_IMM_MISMATCH: o_skip = (i_mem != i_imm);
            OP_REG_MEM_OR: begin
                o_result = i_reg | i_mem;
                o_wr_reg = 1'b1;
            end
            OP_REG_MEM_AND: begin
                o_result = i_reg & i_mem;
                o_wr_reg = 1'b1;
            end
            OP_REG_MEM_XOR: begin
                o_result = i_reg ^ i_mem;
                o_wr_reg = 1'b1;
            end
            OP_MEM_IMM_OR: begin
                o_result = i_mem | i_imm;
                o_wr_mem = 1'b1;
            end
            OP_MEM_IMM_AND: begin
                o_result = i_mem & i_imm;
                o_wr_mem = 1'b1;
            end
            OP_MEM_IMM_XOR: begin
                o_result = i_mem ^ i_imm;
                o_wr_mem = 1'b1;
            end
            OP_IMM_TO_MEM_WRITE: begin
                o_result = i_imm;
                o_wr_mem = 1'b1;
            end
            OP_MEM_TO_REG_COPY: begin
                o_result = i_mem;
                o_wr_reg = 1'b1;
            end
            OP_REG_TO_MEM_COPY: begin
                o_result = i_reg;
                o_wr_mem = 1'b1;
            end
            default: o_result = NIB_ZERO;
        endcase
    end
endmodule

//--- src/ncd_core.sv
/*
 Instruction decoder core with its data memory held in flip-flops.
 Each taken word finishes in one enabled cycle, port reads in two.
 Assumes one instruction word offered at a time with valid/ready,
 a port matrix that answers a read one enabled cycle later, and an
 outside sequencer that drops the word following a skip pulse.
*/
module ncd_core
    import ncd_pkg::*;
#(
    parameter int WORDS = MEM_WORDS
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic [1:0] i_page,
    input wire logic [3:0] i_port_rdata,
    output logic o_ready,
    output logic o_skip,
    output logic o_borrow,
    output logic o_port_rd,
    output logic o_port_wr,
    output logic [1:0] o_port_group,
    output logic [3:0] o_port_code,
    output logic [3:0] o_port_wdata
);
    logic [3:0] mem [WORDS];
    ncd_state_t state;
    logic [5:0] in_addr;
    logic take;
    logic [5:0] op;
    logic [5:0] m_addr;
    logic [5:0] r_addr;
    logic [5:0] far_addr;
    logic [3:0] opd;
    logic [3:0] m_val;
    logic [3:0] r_val;
    logic [3:0] alu_res;
    logic alu_borrow;
    logic alu_set_borrow;
    logic alu_skip;
    logic alu_wr_reg;
    logic alu_wr_mem;
    logic wr_en;
    logic [5:0] wr_addr;
    logic [3:0] wr_data;
    logic is_in;
    logic is_out;

    // =========================================================
    // Field split and operand fetch
    always_comb begin
        // Ready is low right after reset and while a read is pending
        take = i_ce && i_instr_valid && o_ready;
        op = i_instr[OP_MSB:OP_LSB];
        opd = i_instr[OPD_MSB:OPD_LSB];
        m_addr = {i_instr[ROW_MSB:ROW_LSB], i_instr[COL_MSB:COL_LSB]};
        r_addr = {GREG_ROW, opd};
        m_val = mem[m_addr];
        r_val = mem[r_addr];
        // Indirect moves: row from the page input, column from r
        far_addr = {i_page, r_val};
        is_in = (op == OP_PORT_READ_GROUP_ONE) ||
                (op == OP_PORT_READ_GROUP_TWO) ||
                (op == OP_PORT_READ_GROUP_THREE);
        is_out = (op == OP_PORT_WRITE_GROUP_ONE) ||
                 (op == OP_PORT_WRITE_GROUP_TWO) ||
                 (op == OP_PORT_WRITE_GROUP_THREE);
    end

    ncd_alu u_alu (
        .i_op(op),
        .i_reg(r_val),
        .i_mem(m_val),
        .i_imm(opd),
        .i_borrow(o_borrow),
        .o_result(alu_res),
        .o_borrow(alu_borrow),
        .o_set_borrow(alu_set_borrow),
        .o_skip(alu_skip),
        .o_wr_reg(alu_wr_reg),
        .o_wr_mem(alu_wr_mem)
    );

    // =========================================================
    // Single write port select; one store per instruction
    always_comb begin
        wr_en = 1'b0;
        wr_addr = m_addr;
        wr_data = alu_res;
        // Pending port data owns the write port; no word is taken
        if (i_ce && state == NCD_IN_WAIT) begin
            wr_en = 1'b1;
            wr_addr = in_addr;
            wr_data = i_port_rdata;
        end else if (take) begin
            case (op)
                OP_SAME_ROW_COPY: begin
                    wr_en = 1'b1;
                    wr_data = mem[{i_instr[ROW_MSB:ROW_LSB], opd}];
                end
                OP_INDIRECT_DEST_COPY: begin
                    wr_en = 1'b1;
                    wr_addr = far_addr;
                    wr_data = m_val;
                end
                OP_INDIRECT_SRC_COPY: begin
                    wr_en = 1'b1;
                    wr_data = mem[far_addr];
                end
                default: begin
                    wr_en = alu_wr_reg | alu_wr_mem;
                    wr_addr = alu_wr_reg ? r_addr : m_addr;
                end
            endcase
        end
    end

    // =========================================================
    // Data memory
    generate
        for (genvar i = 0; i < WORDS; i++) begin : g_mem
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    mem[i] <= NIB_ZERO;
                end else if (wr_en && wr_addr == 6'(i)) begin
                    mem[i] <= wr_data;
                end
            end
        end
    endgenerate

    // =========================================================
    // Sequencing; a port read costs a second cycle
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= NCD_RUN;
            o_ready <= 1'b0;
        end else if (i_ce) begin
            case (state)
                NCD_RUN: begin
                    o_ready <= 1'b1;
                    if (take && is_in) begin
                        state <= NCD_IN_WAIT;
                        o_ready <= 1'b0;
                    end
                end
                NCD_IN_WAIT: begin
                    state <= NCD_RUN;
                    o_ready <= 1'b1;
                end
                default: state <= NCD_RUN;
            endcase
        end
    end

    // =========================================================
    // Target of a pending port read, kept for its second cycle
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            in_addr <= {GREG_ROW, NIB_ZERO};
        end else if (take && is_in) begin
            in_addr <= m_addr;
        end
    end

    // =========================================================
    // Skip pulse; the sequencer outside drops the next word
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_skip <= 1'b0;
        end else if (i_ce) begin
            o_skip <= take & alu_skip;
        end
    end

    // =========================================================
    // Borrow; only the subtract family moves it, so a chained
    // subtract may follow any number of other instructions
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_borrow <= 1'b0;
        end else if (take && alu_set_borrow) begin
            o_borrow <= alu_borrow;
        end
    end

    // =========================================================
    // Port matrix strobes, one enabled cycle each
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_port_rd <= 1'b0;
            o_port_wr <= 1'b0;
        end else if (i_ce) begin
            o_port_rd <= take & is_in;
            o_port_wr <= take & is_out;
        end
    end

    // =========================================================
    // Port fields hold until the next port instruction
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_port_group <= 2'h0;
            o_port_code <= 4'h0;
            o_port_wdata <= 4'h0;
        end else if (take && (is_in || is_out)) begin
            // Group follows opcode order within each triple
            case (op)
                OP_PORT_READ_GROUP_ONE,
                OP_PORT_WRITE_GROUP_ONE: o_port_group <= GRP_ONE;
                OP_PORT_READ_GROUP_TWO,
                OP_PORT_WRITE_GROUP_TWO: o_port_group <= GRP_TWO;
                default: o_port_group <= GRP_THREE;
            endcase
            o_port_code <= opd;
            o_port_wdata <= m_val;
        end
    end
endmodule

//--- verification/ncd_core_properties.sv
/*
 Port assertions for the decoder core.
 Assumes binding to ncd_core, one clock domain.
*/
module ncd_core_checker
    import ncd_pkg::*;
#(
    parameter int WORDS = MEM_WORDS
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic o_ready,
    input wire logic o_skip,
    input wire logic o_borrow,
    input wire logic o_port_rd,
    input wire logic o_port_wr,
    input wire logic [1:0] o_port_group,
    input wire logic [3:0] o_port_code
);
    // ========
    // Helpers
    logic take;
    logic [5:0] op;
    logic [3:0] opd;
    logic [1:0] in_grp;
    logic [1:0] out_grp;
    assign take = i_ce & i_instr_valid & o_ready;
    assign op = i_instr[OP_MSB:OP_LSB];
    assign opd = i_instr[OPD_MSB:OPD_LSB];
    assign in_grp = op[1:0] + 2'h1;
    assign out_grp = op[1:0] + 2'h2;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_take_in;
        take && op inside {[6'h38:6'h3a]};
    endsequence
    sequence s_issue;
        o_port_rd && !o_ready;
    endsequence
    sequence s_done;
        o_ready && !o_port_rd;
    endsequence
    // ========
    // Assertions
    AST_IN_ISSUE: assert property (
        s_take_in |=> s_issue and (o_port_group == $past(in_grp)
        && o_port_code == $past(opd))) else $error("bad port read");
    AST_IN_DONE: assert property (
        s_take_in ##1 i_ce |=> s_done) else $error("read not closed");
    AST_OUT_ISSUE: assert property (
        take && op inside {[6'h3b:6'h3d]} |=> o_port_wr
        && o_port_group == $past(out_grp) && o_port_code == $past(opd))
        else $error("bad port write");
    AST_NO_SKIP: assert property (
        take && op inside {6'h06, 6'h07, 6'h0e, 6'h0f, 6'h16, 6'h17,
        6'h18, 6'h1e, 6'h24, 6'h25, [6'h38:6'h3d]} |=> !o_skip)
        else $error("skip on plain op");
    AST_SKIP_ON_BORROW: assert property (
        take && op inside {6'h19, 6'h1c} |=> o_skip == o_borrow)
        else $error("skip not borrow");
    AST_SKIP_NO_BORROW: assert property (
        take && op inside {6'h1a, 6'h1d} |=> o_skip != o_borrow)
        else $error("skip not inverse borrow");
    AST_MASK_ZERO_SKIP: assert property (
        take && opd == 4'h0 && op inside {6'h35, 6'h37} |=> o_skip)
        else $error("empty mask no skip");
    AST_MASK_ZERO_STAY: assert property (
        take && opd == 4'h0 && op inside {6'h34, 6'h36} |=> !o_skip)
        else $error("empty mask skipped");
    AST_BORROW_CAUSE: assert property (
        $changed(o_borrow) |-> $past(take)
        && $past(op) inside {[6'h18:6'h1d]}) else $error("stray borrow");
endmodule

bind ncd_core ncd_core_checker #(.WORDS(WORDS)) i_chk (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_instr_valid(i_instr_valid),
    .i_instr(i_instr),
    .o_ready(o_ready),
    .o_skip(o_skip),
    .o_borrow(o_borrow),
    .o_port_rd(o_port_rd),
    .o_port_wr(o_port_wr),
    .o_port_group(o_port_group),
    .o_port_code(o_port_code)
);

//--- verification/ncd_port_model.sv
/*
 Port matrix model: answers reads with code plus group.
 Assumes the read strobe qualifies group and code.
*/
module ncd_port_model
    import ncd_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_port_rd,
    input wire logic [1:0] i_port_group,
    input wire logic [3:0] i_port_code,
    output logic [3:0] o_port_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========
    // Read side
    logic [3:0] last = 4'h0;
    // Idle bus shows inverse of last value, so stale data never matches
    always_comb begin
        if (i_port_rd) begin
            o_port_rdata = i_port_code + {2'h0, i_port_group};
        end else begin
            o_port_rdata = ~last;
        end
    end
    always @(posedge i_ref_clk) begin
        if (i_port_rd) begin
            last <= o_port_rdata;
        end
    end
endmodule

//--- verification/ncd_core_tb_top.sv
/*
 Self-checking bench for the decoder core.
 Assumes the port model answers reads; one test drops clock enable.
*/
module ncd_core_tb_top import ncd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic i_instr_valid = 1'b0;
    logic [15:0] i_instr = 16'h0000;
    logic [1:0] i_page = 2'h0;
    logic [3:0] i_port_rdata;
    logic o_ready, o_skip, o_borrow, o_port_rd, o_port_wr;
    logic [1:0] o_port_group;
    logic [3:0] o_port_code, o_port_wdata;
    int fails = 0;
    int num_checks = 0;

    ncd_core i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_page(i_page),
        .i_port_rdata(i_port_rdata), .o_ready(o_ready), .o_skip(o_skip),
        .o_borrow(o_borrow), .o_port_rd(o_port_rd), .o_port_wr(o_port_wr),
        .o_port_group(o_port_group), .o_port_code(o_port_code),
        .o_port_wdata(o_port_wdata));
    ncd_port_model i_port (.i_ref_clk(i_ref_clk), .i_port_rd(o_port_rd),
        .i_port_group(o_port_group), .i_port_code(o_port_code),
        .o_port_rdata(i_port_rdata));

    initial begin
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    // ========
    // Compares and bus cycle
    task automatic chk_nib(string n, logic [3:0] e, logic [3:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(string n, logic e, logic g);
        chk_nib(n, {3'h0, e}, {3'h0, g});
    endtask
    // Ends in the answer cycle, so one-cycle pulses are still up
    task automatic send(logic [5:0] op, logic [1:0] row, logic [3:0] col,
        logic [3:0] opd);
        int n;
        n = 0;
        @(negedge i_ref_clk);
        while (o_ready !== 1'b1 && n < 20) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk_bit("ready", 1'b1, o_ready);
        @(posedge i_ref_clk);
        i_instr <= {op, row, col, opd};
        i_instr_valid <= 1'b1;
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b0;
        @(negedge i_ref_clk);
    endtask
    task automatic put(logic [1:0] row, logic [3:0] col, logic [3:0] v);
        send(OP_IMM_TO_MEM_WRITE, row, col, v);
        chk_bit("imm skip", 1'b0, o_skip);
    endtask
    task automatic peek(logic [1:0] row, logic [3:0] col, string n,
        logic [3:0] e);
        send(OP_PORT_WRITE_GROUP_ONE, row, col, 4'h0);
        chk_nib(n, e, o_port_wdata);
    endtask

    // ========
    // Scenarios
    task automatic t_move();
        put(2'h1, 4'h3, 4'ha);
        send(OP_MEM_TO_REG_COPY, 2'h1, 4'h3, 4'h5);
        peek(GREG_ROW, 4'h5, "load", 4'ha);
        send(OP_REG_TO_MEM_COPY, 2'h3, 4'h2, 4'h5);
        peek(2'h3, 4'h2, "store", 4'ha);
        $display("test move done");
    endtask
    task automatic t_port();
        logic [1:0] g;
        for (int k = 0; k < 3; k++) begin
            g = 2'(k + 1);
            send(OP_PORT_READ_GROUP_ONE + 6'(k), 2'h2, 4'(k), 4'h9);
            chk_bit("rd strobe", 1'b1, o_port_rd);
            chk_bit("rd ready", 1'b0, o_ready);
            chk_nib("rd grp", {2'h0, g}, {2'h0, o_port_group});
            chk_nib("rd code", 4'h9, o_port_code);
            send(OP_PORT_WRITE_GROUP_ONE + 6'(k), 2'h2, 4'(k), 4'h6);
            chk_bit("wr strobe", 1'b1, o_port_wr);
            chk_nib("wr group", {2'h0, g}, {2'h0, o_port_group});
            chk_nib("wr code", 4'h6, o_port_code);
            chk_nib("wr data", 4'h9 + {2'h0, g}, o_port_wdata);
        end
        $display("test port done");
    endtask
    task automatic sub_case(logic [5:0] op, logic [3:0] a, logic [3:0] b,
        logic bin);
        logic [4:0] d;
        logic s;
        d = {1'b0, a} - {1'b0, b} - {4'h0, bin & (op > 6'h1a)};
        s = op inside {6'h19, 6'h1c} ? d[4] : op inside {6'h1a, 6'h1d};
        s = op inside {6'h1a, 6'h1d} ? ~d[4] : s;
        put(GREG_ROW, 4'h2, {3'h0, ~bin});
        put(2'h1, 4'hf, 4'h1);
        send(OP_REG_MINUS_MEM, 2'h1, 4'hf, 4'h2);
        put(GREG_ROW, 4'h1, a);
        put(2'h1, 4'h0, b);
        send(op, 2'h1, 4'h0, 4'h1);
        chk_bit("borrow", d[4], o_borrow);
        chk_bit("sub skip", s, o_skip);
        peek(GREG_ROW, 4'h1, "difference", d[3:0]);
    endtask
    task automatic t_sub();
        sub_case(6'h18, 4'h3, 4'h5, 1'b0);
        sub_case(6'h19, 4'h3, 4'h5, 1'b1);
        sub_case(6'h19, 4'h7, 4'h2, 1'b0);
        sub_case(6'h1a, 4'h3, 4'h5, 1'b0);
        sub_case(6'h1a, 4'h7, 4'h7, 1'b1);
        sub_case(6'h1b, 4'h5, 4'h5, 1'b1);
        sub_case(6'h1c, 4'h5, 4'h4, 1'b1);
        sub_case(6'h1d, 4'h5, 4'h4, 1'b1);
        sub_case(6'h1d, 4'h0, 4'h0, 1'b1);
        $display("test sub done");
    endtask
    function automatic logic want(logic [5:0] op, logic [3:0] r,
        logic [3:0] m, logic [3:0] i);
        case (op)
            6'h20: want = (r & m) == m;
            6'h21: want = (r & m) == 4'h0;
            6'h22: want = r == m;
            6'h23: want = r != m;
            6'h30: want = m < i;
            6'h31: want = m >= i;
            6'h32: want = m == i;
            6'h33: want = m != i;
            6'h34: want = (m & i) != i;
            6'h35: want = (m & i) == i;
            6'h36: want = (m & i) != 4'h0;
            default: want = (m & i) == 4'h0;
        endcase
    endfunction
    task automatic t_cmp();
        logic [5:0] ops [12] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h30, 6'h31,
            6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37};
        logic [11:0] vals [4] = '{12'h666, 12'h54c, 12'ha20, 12'h3c5};
        logic [3:0] r, m, i;
        logic w;
        foreach (ops[k]) begin
            foreach (vals[j]) begin
                {r, m, i} = vals[j];
                put(GREG_ROW, 4'h4, r);
                put(2'h3, 4'h1, m);
                send(ops[k], 2'h3, 4'h1, ops[k] < 6'h24 ? 4'h4 : i);
                w = want(ops[k], r, m, i);
                if (ops[k] < 6'h30) begin
                    chk_bit("reg skip", w, o_skip);
                end else if (ops[k] < 6'h34) begin
                    chk_bit("cmp skip", w, o_skip);
                end else if (ops[k] < 6'h36) begin
                    chk_bit("ones skip", w, o_skip);
                end else begin
                    chk_bit("zeros skip", w, o_skip);
                end
            end
            peek(2'h3, 4'h1, "kept mem", m);
            peek(GREG_ROW, 4'h4, "kept reg", r);
        end
        $display("test compare done");
    endtask
    task automatic t_logic();
        logic [5:0] ops [6] = '{6'h16, 6'h17, 6'h1e, 6'h06, 6'h07, 6'h0e};
        logic [3:0] e [3] = '{4'he, 4'h8, 4'h6};
        foreach (ops[k]) begin
            put(GREG_ROW, 4'h6, 4'hc);
            put(2'h1, 4'h9, k < 3 ? 4'ha : 4'hc);
            send(ops[k], 2'h1, 4'h9, k < 3 ? 4'h6 : 4'ha);
            chk_bit("logic skip", 1'b0, o_skip);
            if (k < 3) begin
                peek(GREG_ROW, 4'h6, "reg logic", e[k]);
            end else begin
                peek(2'h1, 4'h9, "mem logic", e[k - 3]);
            end
        end
        $display("test logic done");
    endtask
    task automatic t_moves();
        @(posedge i_ref_clk);
        i_page <= 2'h3;
        put(2'h2, 4'h3, 4'h7);
        send(OP_SAME_ROW_COPY, 2'h2, 4'h8, 4'h3);
        peek(2'h2, 4'h8, "same row", 4'h7);
        put(GREG_ROW, 4'h7, 4'hb);
        put(2'h1, 4'h1, 4'h9);
        send(OP_INDIRECT_DEST_COPY, 2'h1, 4'h1, 4'h7);
        peek(2'h3, 4'hb, "ind dest", 4'h9);
        put(2'h3, 4'hb, 4'h5);
        send(OP_INDIRECT_SRC_COPY, 2'h2, 4'h0, 4'h7);
        peek(2'h2, 4'h0, "ind src", 4'h5);
        $display("test moves done");
    endtask
    // A word offered while enable is low must not be taken
    task automatic t_freeze();
        put(2'h2, 4'h5, 4'h3);
        @(posedge i_ref_clk);
        i_ce <= 1'b0;
        send(OP_IMM_TO_MEM_WRITE, 2'h2, 4'h5, 4'hc);
        chk_bit("frozen ready", 1'b1, o_ready);
        @(posedge i_ref_clk);
        i_ce <= 1'b1;
        peek(2'h2, 4'h5, "frozen mem", 4'h3);
        $display("test freeze done");
    endtask

    // ========
    // Run control
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        t_move();
        t_port();
        t_sub();
        t_cmp();
        t_logic();
        t_moves();
        t_freeze();
        complete_run();
    end
    // Whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        fails++;
        complete_run();
    end
endmodule
